// [hw/wdtrs_core.sv]
/*
  Watchdog timer with shared prescaler, device reset timer and reset-cause
  flags, as seen from inside the device.
  Assumes all inputs but nrst_i are synchronous to mclk_i, that wdt_osc_tick_i is one
  pulse per period of the watchdog's own oscillator, and that the core
  gives one-cycle instruction pulses only while it runs.
*/
`timescale 1ns/100ps

`include "wdtrs_regs.svh"

module wdtrs_core
  import wdtrs_pkg::*;
#(
  parameter int unsigned WDT_BASE_CYC = `WDTRS_WDT_PERIOD_CYC,
  parameter int unsigned DRT_POR_CYC = `WDTRS_DRT_POR_CYC,
  parameter int unsigned DRT_SUB_CYC = `WDTRS_DRT_SUB_CYC
)
(
  input wire logic mclk_i, // 100 MHz clock
  input wire logic nrst_i, // Power-on reset, async
  input wire logic ce_i, // Clock enable
  input wire logic wdt_osc_tick_i, // Watchdog oscillator tick
  input wire logic watchdog_enable_fuse_i, // Fuse, 0 disables
  input wire wdtrs_osc_mode_type osc_mode_i, // Oscillator selection
  input wire logic external_reset_pin_n_i, // External reset, low
  input wire logic watchdog_clear_instr_i, // Clear instruction
  input wire logic sleep_instr_i, // Sleep instruction
  input wire logic pin_change_i, // Pin change event
  input wire logic [1:0] reg_addr_i, // Register address
  input wire logic [7:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  output logic [7:0] reg_rdata_o, // Read data
  output logic cpu_reset_o, // Holds processor in reset
  output logic powerdown_mode_o, // Device asleep
  output wdtrs_flags_type flags_o, // Reset-cause flags
  output wdtrs_option_type option_o // Configuration fields
);

  // -------------------------------------------------------------------
  // Constants and helpers
  // -------------------------------------------------------------------
  localparam logic [20:0] BASE_LAST = 21'(WDT_BASE_CYC - 1);
  localparam logic [20:0] DRT_POR_LAST = 21'(DRT_POR_CYC - 1);
  localparam logic [20:0] DRT_SUB_LAST = 21'(DRT_SUB_CYC - 1);

  // Last prescaler count for a ratio of 1:2^ratio
  function automatic logic [6:0] post_last(input logic [2:0] ratio);
    post_last = 7'((8'h01 << ratio) - 8'h01);
  endfunction : post_last

  function automatic logic is_rc_mode(input wdtrs_osc_mode_type m);
    is_rc_mode = (m == internal_rc_osc_mode) ||
                 (m == external_rc_osc_mode);
  endfunction : is_rc_mode

  wdtrs_state_type s;
  wdtrs_state_type next_s;

  logic wdt_on;
  logic base_wrap;
  logic ev_wdt;
  logic ev_ext;
  logic ev_pin;
  logic ev_any;
  logic clr_take;
  logic sleep_take;
  logic [20:0] drt_last;

  // -------------------------------------------------------------------
  // Events
  // -------------------------------------------------------------------
  assign wdt_on = watchdog_enable_fuse_i;
  assign base_wrap = wdt_osc_tick_i && (s.base_cnt == BASE_LAST);
  // Prescaler only stretches the period when assigned to the watchdog
  assign ev_wdt = wdt_on && !s.in_reset && base_wrap &&
                  (!s.opt.prescaler_assign ||
                   s.post_cnt == post_last(s.opt.prescale_ratio));
  assign ev_ext = !external_reset_pin_n_i;
  assign ev_pin = s.asleep && pin_change_i && !s.opt.pin_wake_disable;
  assign ev_any = ev_ext || ev_wdt || ev_pin;
  assign clr_take = watchdog_clear_instr_i && !s.in_reset && !s.asleep;
  assign sleep_take = sleep_instr_i && !s.in_reset && !s.asleep;
  assign drt_last = (s.por_drt || !is_rc_mode(osc_mode_i)) ?
                    DRT_POR_LAST : DRT_SUB_LAST;

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.rdata = 8'h00;

    // Watchdog and shared prescaler
    if (!wdt_on || s.in_reset)
    begin
      next_s.base_cnt = 21'h000000;
      next_s.post_cnt = 7'h00;
    end
    else if (wdt_osc_tick_i)
    begin
      if (base_wrap)
      begin
        next_s.base_cnt = 21'h000000;
        next_s.post_cnt = s.opt.prescaler_assign ?
                          s.post_cnt + 7'h01 : 7'h00;
      end
      else
      begin
        next_s.base_cnt = s.base_cnt + 21'h000001;
      end
    end

    // Reset timer holds the core until it has run out
    if (s.in_reset)
    begin
      if (ev_ext)
      begin
        next_s.drt_cnt = 21'h000000;
      end
      else if (s.drt_cnt == drt_last)
      begin
        next_s.in_reset = 1'b0;
        next_s.por_drt = 1'b0;
        next_s.drt_cnt = 21'h000000;
      end
      else
      begin
        next_s.drt_cnt = s.drt_cnt + 21'h000001;
      end
    end

    // Instructions and software writes while running
    if (clr_take)
    begin
      next_s.base_cnt = 21'h000000;
      next_s.post_cnt = 7'h00;
      next_s.flags.timeout_flag = 1'b1;
      next_s.flags.powerdown_flag = 1'b1;
    end
    if (sleep_take)
    begin
      next_s.asleep = 1'b1;
      next_s.base_cnt = 21'h000000;
      next_s.post_cnt = 7'h00;
      next_s.flags.timeout_flag = 1'b1;
      next_s.flags.powerdown_flag = 1'b0;
    end
    if (reg_wr_i && !s.in_reset && reg_addr_i == `WDTRS_OFS_OPTION)
    begin
      next_s.opt = wdtrs_option_type'(reg_wdata_i);
    end
    if (reg_rd_i && reg_addr_i == `WDTRS_OFS_STATUS)
    begin
      next_s.rdata[`WDTRS_STS_PIN_WAKE] = s.flags.pin_wake_flag;
      next_s.rdata[`WDTRS_STS_TIMEOUT] = s.flags.timeout_flag;
      next_s.rdata[`WDTRS_STS_POWERDOWN] = s.flags.powerdown_flag;
    end

    // Any reset source; external pin first, then watchdog, then pin wake
    if (ev_any)
    begin
      next_s.opt = wdtrs_option_type'(`WDTRS_OPTION_RST);
      next_s.asleep = 1'b0;
      next_s.in_reset = 1'b1;
      next_s.drt_cnt = 21'h000000;
      next_s.base_cnt = 21'h000000;
      next_s.post_cnt = 7'h00;
      // Reset wins over an instruction taken in the same cycle
      next_s.flags = s.flags;
      next_s.flags.pin_wake_flag = 1'b0;
      if (ev_ext)
      begin
        // A pulse while running leaves the cause flags alone
        if (s.asleep)
        begin
          next_s.flags.timeout_flag = 1'b1;
          next_s.flags.powerdown_flag = 1'b0;
        end
        else
        begin
          next_s.flags.pin_wake_flag = s.flags.pin_wake_flag;
        end
      end
      else if (ev_wdt)
      begin
        next_s.flags.timeout_flag = 1'b0;
        if (s.asleep)
        begin
          next_s.flags.powerdown_flag = 1'b0;
        end
      end
      else
      begin
        next_s.flags.pin_wake_flag = 1'b1;
        next_s.flags.timeout_flag = 1'b1;
        next_s.flags.powerdown_flag = 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s <= '0;
      s.opt <= wdtrs_option_type'(`WDTRS_OPTION_RST);
      s.flags.timeout_flag <= 1'b1;
      s.flags.powerdown_flag <= 1'b1;
      s.in_reset <= 1'b1;
      s.por_drt <= 1'b1;
    end
    else if (ce_i)
    begin
      s <= next_s;
    end
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  assign reg_rdata_o = s.rdata;
  assign cpu_reset_o = s.in_reset;
  assign powerdown_mode_o = s.asleep;
  assign flags_o = s.flags;
  assign option_o = s.opt;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  sequence s_reset_entry;
    ##1 cpu_reset_o && s.opt == 8'hFF && s.drt_cnt == 21'h000000;
  endsequence

  sequence s_drt_release;
    s.in_reset && !ev_ext && ce_i && s.drt_cnt == drt_last;
  endsequence

  a_wdt_reset_entry: assert property (@(posedge mclk_i)
    disable iff (!nrst_i) (ev_wdt && ce_i) |-> s_reset_entry)
    else $error("watchdog time-out did not reset the device");

  a_wdt_flag_clear: assert property (@(posedge mclk_i)
    disable iff (!nrst_i) (ev_wdt && ce_i) |=> !flags_o.timeout_flag)
    else $error("timeout flag not cleared on time-out");

  a_fuse_blocks_wdt: assert property (@(posedge mclk_i)
    disable iff (!nrst_i) (!watchdog_enable_fuse_i && ce_i) |=>
    (s.base_cnt == 21'h000000 && s.post_cnt == 7'h00))
    else $error("watchdog counted while fused off");

  a_drt_release_time: assert property (@(posedge mclk_i)
    disable iff (!nrst_i) s_drt_release |=> !cpu_reset_o)
    else $error("reset timer did not release the core");

  a_crystal_drt: assert property (@(posedge mclk_i)
    disable iff (!nrst_i) (s.in_reset && !is_rc_mode(osc_mode_i) &&
    s.drt_cnt < DRT_POR_LAST && ce_i) |=> cpu_reset_o)
    else $error("crystal mode left reset before the long delay");

  a_tick_only_count: assert property (@(posedge mclk_i)
    disable iff (!nrst_i) (wdt_on && !s.in_reset && !wdt_osc_tick_i &&
    !clr_take && !sleep_take && !ev_any && ce_i) |=> $stable(s.base_cnt))
    else $error("watchdog counted without an oscillator tick");

  a_base_in_range: assert property (@(posedge mclk_i)
    disable iff (!nrst_i) s.base_cnt <= BASE_LAST)
    else $error("watchdog base count passed its period");

  a_option_reset: assert property (@(posedge mclk_i)
    disable iff (!nrst_i) (ev_any && ce_i) |-> s_reset_entry)
    else $error("configuration register not all ones after reset");

  a_option_write: assert property (@(posedge mclk_i)
    disable iff (!nrst_i) (reg_wr_i && reg_addr_i == `WDTRS_OFS_OPTION &&
    !s.in_reset && !ev_any && ce_i) |=> option_o == $past(reg_wdata_i))
    else $error("configuration write did not land");

  a_clear_restarts: assert property (@(posedge mclk_i)
    disable iff (!nrst_i) (clr_take && !ev_any && ce_i) |=>
    (s.base_cnt == 21'h000000 && s.post_cnt == 7'h00 &&
     flags_o.timeout_flag))
    else $error("clear instruction did not restart the watchdog");

  a_sleep_flags: assert property (@(posedge mclk_i)
    disable iff (!nrst_i) (sleep_take && !ev_any && ce_i) |=>
    (powerdown_mode_o && flags_o.timeout_flag &&
     !flags_o.powerdown_flag && s.base_cnt == 21'h000000))
    else $error("sleep entry flags or counter wrong");

  a_sleep_only_instr: assert property (@(posedge mclk_i)
    disable iff (!nrst_i) $rose(powerdown_mode_o) |->
    $past(sleep_instr_i))
    else $error("power-down entered without sleep instruction");

  a_wdt_wake_flags: assert property (@(posedge mclk_i)
    disable iff (!nrst_i) (ev_wdt && !ev_ext && s.asleep && ce_i) |=>
    (flags_o == 3'h0 && !powerdown_mode_o))
    else $error("flags wrong after watchdog wake");

  a_wdt_run_pd: assert property (@(posedge mclk_i)
    disable iff (!nrst_i) (ev_wdt && !ev_ext && !s.asleep && ce_i) |=>
    (flags_o.powerdown_flag == $past(flags_o.powerdown_flag) &&
     !flags_o.pin_wake_flag))
    else $error("running time-out changed powerdown flag");

  a_pin_wake_flags: assert property (@(posedge mclk_i)
    disable iff (!nrst_i) (ev_pin && !ev_ext && !ev_wdt && ce_i) |=>
    (flags_o.pin_wake_flag && flags_o.timeout_flag &&
     !flags_o.powerdown_flag))
    else $error("flags wrong after pin wake");

  a_ext_run_keeps: assert property (@(posedge mclk_i)
    disable iff (!nrst_i) (ev_ext && !s.asleep && ce_i) |=>
    $stable(flags_o))
    else $error("external pulse while running changed flags");

  a_wdt_drt_restart: assert property (@(posedge mclk_i)
    disable iff (!nrst_i) (ev_wdt && ce_i) |-> s_reset_entry ##1 cpu_reset_o)
    else $error("time-out did not hold the reset timer period");

endmodule : wdtrs_core

// [inc/wdtrs_pkg.sv]
/*
  Types of the watchdog and reset-status block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package wdtrs_pkg;

  // -------------------------------------------------------------------
  // Oscillator selection
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    internal_rc_osc_mode,
    external_rc_osc_mode,
    high_speed_crystal_mode,
    standard_crystal_mode,
    low_power_crystal_mode
  } wdtrs_osc_mode_type;

  // -------------------------------------------------------------------
  // Timer configuration register layout
  // -------------------------------------------------------------------
  typedef struct packed {
    logic pin_wake_disable;
    logic pullup_disable;
    logic timer_clock_source;
    logic timer_edge_select;
    logic prescaler_assign;
    logic [2:0] prescale_ratio;
  } wdtrs_option_type;

  typedef struct packed {
    logic pin_wake_flag;
    logic timeout_flag;
    logic powerdown_flag;
  } wdtrs_flags_type;

  // -------------------------------------------------------------------
  // Whole state of the block
  // -------------------------------------------------------------------
  typedef struct packed {
    wdtrs_option_type opt;
    wdtrs_flags_type flags;
    logic asleep;
    logic in_reset;
    logic por_drt;
    logic [20:0] drt_cnt;
    logic [20:0] base_cnt;
    logic [6:0] post_cnt;
    logic [7:0] rdata;
  } wdtrs_state_type;

endpackage : wdtrs_pkg

// [inc/wdtrs_regs.svh]
/*
  Register offsets, field positions, reset values and timing counts of the
  watchdog and reset-status block.
  Assumes a 100 MHz system clock and an 8-bit register port.
*/
`ifndef WDTRS_REGS_SVH
`define WDTRS_REGS_SVH

// ---------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------
`define WDTRS_OFS_OPTION 2'h0
`define WDTRS_OFS_STATUS 2'h1

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define WDTRS_OPT_PIN_WAKE_DIS 7
`define WDTRS_OPT_PULLUP_DIS 6
`define WDTRS_OPT_CLK_SRC 5
`define WDTRS_OPT_EDGE_SEL 4
`define WDTRS_OPT_PRESC_ASSIGN 3
`define WDTRS_STS_PIN_WAKE 7
`define WDTRS_STS_TIMEOUT 4
`define WDTRS_STS_POWERDOWN 3

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define WDTRS_OPTION_RST 8'hFF

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define WDTRS_CLK_MHZ 100
`define WDTRS_WDT_PERIOD_US 18000
`define WDTRS_DRT_POR_US 18000
`define WDTRS_DRT_SUB_US 300
`define WDTRS_WDT_PERIOD_CYC (`WDTRS_WDT_PERIOD_US * `WDTRS_CLK_MHZ)
`define WDTRS_DRT_POR_CYC (`WDTRS_DRT_POR_US * `WDTRS_CLK_MHZ)
`define WDTRS_DRT_SUB_CYC (`WDTRS_DRT_SUB_US * `WDTRS_CLK_MHZ)

`endif

// [test/tb.sv]
/*
  Self-checking bench of the watchdog and reset-status block.
  Assumes the core model beside it and shortened timer counts.
*/
`timescale 1ns/100ps

module tb
  import wdtrs_pkg::*;
();
  localparam int BASE = 20;
  localparam int POR = 40;
  localparam int SUB = 10;
  logic mclk_i;
  logic nrst_i;
  logic tick, fuse, ext_n, pin, wr, rd, clr_req, slp_req, rogue, ce;
  logic clr, slp, cpu_rst, pdm, rd_seen;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, v;
  wdtrs_osc_mode_type mode;
  wdtrs_flags_type flags;
  wdtrs_option_type opt;
  logic [7:0] exp_q[$];
  int mismatches, n_compared, n;

  wdtrs_core #(.WDT_BASE_CYC(BASE), .DRT_POR_CYC(POR),
    .DRT_SUB_CYC(SUB)) u_wdtrs_core (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .ce_i(ce), .wdt_osc_tick_i(tick), .watchdog_enable_fuse_i(fuse),
    .osc_mode_i(mode), .external_reset_pin_n_i(ext_n),
    .watchdog_clear_instr_i(clr), .sleep_instr_i(slp),
    .pin_change_i(pin), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .cpu_reset_o(cpu_rst), .powerdown_mode_o(pdm), .flags_o(flags),
    .option_o(opt));

  wdtrs_cpu_model u_wdtrs_cpu_model (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .cpu_reset_i(cpu_rst), .powerdown_i(pdm), .clear_req_i(clr_req),
    .sleep_req_i(slp_req), .rogue_i(rogue), .clear_o(clr),
    .sleep_o(slp));

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] e);
    n_compared++;
    if (seen !== e)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, e);
    end
  endtask : chk

  task automatic results;
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // Timer figures carry some pipeline slack
  task automatic near(input int cnt, input int lo);
    chk(8'(cnt >= lo - 1 && cnt <= lo + 4), 8'h01);
  endtask : near

  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
  endtask : rd_reg

  // 0 clear, 1 sleep, else pin change
  task automatic issue(input int k);
    @(posedge mclk_i);
    case (k)
      0: clr_req <= 1'b1;
      1: slp_req <= 1'b1;
      default: pin <= 1'b1;
    endcase
    @(posedge mclk_i);
    {clr_req, slp_req, pin} <= 3'b000;
  endtask : issue

  task automatic ext_rst;
    @(posedge mclk_i);
    ext_n <= 1'b0;
    repeat (3) @(posedge mclk_i);
    ext_n <= 1'b1;
  endtask : ext_rst

  // Counts cycles until the core reset reaches lvl
  task automatic wait_rst(input logic lvl, output int cnt);
    cnt = 0;
    while (cpu_rst !== lvl && cnt < 5000)
    begin
      @(negedge mclk_i);
      cnt++;
    end
  endtask : wait_rst

  // ------------------------------------------------------------------
  // Clock, monitor, watchdog
  // ------------------------------------------------------------------
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk_i)
  begin
    if (rd_seen)
      chk(rdata, exp_q.pop_front());
    rd_seen <= rd;
  end

  initial
  begin
    #400000;
    mismatches++;
    results();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    {nrst_i, tick, fuse, ext_n, pin, wr, rd} = 7'b0111000;
    {ce, clr_req, slp_req, rogue} = 4'h8;
    {addr, wdata} = 10'h000;
    mode = internal_rc_osc_mode;
    mismatches = 0;
    n_compared = 0;
    void'($urandom(32'hC062));
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'b1;
    wait_rst(1'b0, n);
    near(n, POR);
    rd_reg(2'h1, 8'h18);
    rd_reg(2'h0, 8'h00);
    rd_reg(2'h2, 8'h00);
    wr_reg(2'h3, 8'h00);
    @(negedge mclk_i);
    chk(opt, 8'hFF);
    issue(0);
    wait_rst(1'b1, n);
    near(n, BASE * 128);
    rogue <= 1'b1;
    issue(1);
    rogue <= 1'b0;
    repeat (2) @(negedge mclk_i);
    chk(8'(pdm), 8'h00);
    wait_rst(1'b0, n);
    rd_reg(2'h1, 8'h08);
    for (int m = 0; m < 5; m++)
    begin
      mode <= wdtrs_osc_mode_type'(3'(m));
      ext_rst();
      wait_rst(1'b0, n);
      near(n, m < 2 ? SUB : POR);
      rd_reg(2'h1, 8'h08);
    end
    mode <= internal_rc_osc_mode;
    for (int i = 0; i < 3; i++)
    begin
      v = {1'b1, 3'($urandom), 1'(i > 0), 3'(i > 0 ? 2 * i : $urandom)};
      wr_reg(2'h0, v);
      @(negedge mclk_i);
      chk(opt, v);
      issue(0);
      wait_rst(1'b1, n);
      near(n, BASE << (i > 0 ? 2 * i : 0));
      wr_reg(2'h0, 8'h00);
      @(negedge mclk_i);
      chk(opt, 8'hFF);
      wait_rst(1'b0, n);
    end
    wr_reg(2'h0, 8'hF0);
    repeat (8)
    begin
      repeat (12) @(posedge mclk_i);
      issue(0);
    end
    chk(8'(cpu_rst), 8'h00);
    rd_reg(2'h1, 8'h18);
    // Frozen enable and a silent oscillator must both stall the count
    ce <= 1'b0;
    repeat (40) @(posedge mclk_i);
    {ce, tick} <= 2'b10;
    repeat (40) @(posedge mclk_i);
    tick <= 1'b1;
    chk(8'(cpu_rst), 8'h00);
    issue(0);
    repeat (15) @(posedge mclk_i);
    issue(1);
    repeat (2) @(negedge mclk_i);
    chk(8'(pdm), 8'h01);
    wait_rst(1'b1, n);
    near(n, BASE - 1);
    wait_rst(1'b0, n);
    chk(8'(pdm), 8'h00);
    rd_reg(2'h1, 8'h00);
    issue(1);
    ext_rst();
    wait_rst(1'b0, n);
    rd_reg(2'h1, 8'h10);
    wr_reg(2'h0, 8'h70);
    issue(0);
    issue(1);
    rd_reg(2'h1, 8'h10);
    issue(2);
    wait_rst(1'b1, n);
    wait_rst(1'b0, n);
    rd_reg(2'h1, 8'h90);
    fuse <= 1'b0;
    wr_reg(2'h0, 8'hF0);
    issue(0);
    repeat (300) @(posedge mclk_i);
    chk(8'(cpu_rst), 8'h00);
    results();
  end
endmodule : tb

// [test/wdtrs_cpu_model.sv]
/*
  Processor core model: issues clear and sleep instruction pulses.
  Assumes one-cycle requests from the bench, driven on the clock edge.
*/
`timescale 1ns/100ps

module wdtrs_cpu_model
(
  input wire logic mclk_i, // Clock
  input wire logic nrst_i, // Reset, low
  input wire logic cpu_reset_i, // Core held in reset
  input wire logic powerdown_i, // Core asleep
  input wire logic clear_req_i, // Clear request
  input wire logic sleep_req_i, // Sleep request
  input wire logic rogue_i, // Issue even while halted
  output logic clear_o, // Clear instruction
  output logic sleep_o // Sleep instruction
);
  logic run;

  // A halted core fetches nothing; rogue_i breaks this on purpose
  assign run = (!cpu_reset_i && !powerdown_i) || rogue_i;

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      clear_o <= 1'b0;
      sleep_o <= 1'b0;
    end
    else
    begin
      clear_o <= clear_req_i && run;
      sleep_o <= sleep_req_i && run;
    end
  end
endmodule : wdtrs_cpu_model
